// ---- pcs_framer_pkg.sv ----
// Shared code-group values, classes and state types for the ordered-set framer.
package pcs_framer_pkg;
    localparam logic [7:0] CG_K28_5    = 8'hbc;
    localparam logic [7:0] CG_D21_5    = 8'hb5;
    localparam logic [7:0] CG_D2_2     = 8'h42;
    localparam logic [7:0] CG_D16_2    = 8'h50;
    localparam logic [7:0] CG_D5_6     = 8'hc5;
    localparam logic [7:0] CG_SOP      = 8'hfb;
    localparam logic [7:0] CG_EOP      = 8'hfd;
    localparam logic [7:0] CG_EXTEND   = 8'hf7;
    localparam logic [7:0] CG_ERRPROP  = 8'hfe;
    localparam logic [7:0] PREAMBLE    = 8'h55;
    localparam logic [7:0] EXTEND_CODE = 8'h0f;

    typedef enum logic [2:0] {
        CLS_DATA,
        CLS_SOP,
        CLS_EOP,
        CLS_EXTEND,
        CLS_ERRPROP,
        CLS_OTHER
    } cg_class_t;

    typedef enum {
        TX_IDLE,
        TX_SOP,
        TX_DATA,
        TX_EXT2,
        TX_EXT1,
        TX_CFG1,
        TX_CFG2,
        TX_CFG3
    } tx_state_t;

    typedef enum {
        RX_IDLE,
        RX_FRAME,
        RX_TERM,
        RX_TERM_R
    } rx_state_t;
endpackage

// ---- reset_sync.sv ----
// Two-stage release synchroniser for the active-low reset.
`timescale 1ns/1ps
`default_nettype none
module reset_sync (
    input  wire logic i_clock,
    input  wire logic i_rstn,
    output logic      o_rstn
);
    logic stage1;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            stage1 <= 1'b0;
            o_rstn <= 1'b0;
        end else begin
            stage1 <= 1'b1;
            o_rstn <= stage1;
        end
    end
endmodule
`default_nettype wire

// ---- cg_classify.sv ----
// Registered classifier for one received code group.
`timescale 1ns/1ps
`default_nettype none
module cg_classify
    import pcs_framer_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_rstn,
    input  wire logic [7:0] i_data,
    input  wire logic       i_k,
    output logic [7:0]      o_data,
    output cg_class_t       o_class
);
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_data  <= 8'h00;
            o_class <= CLS_OTHER;
        end else begin
            o_data <= i_data;
            if (!i_k) begin
                o_class <= CLS_DATA;
            end else begin
                unique case (i_data)
                    CG_SOP:     o_class <= CLS_SOP;
                    CG_EOP:     o_class <= CLS_EOP;
                    CG_EXTEND:  o_class <= CLS_EXTEND;
                    CG_ERRPROP: o_class <= CLS_ERRPROP;
                    default:    o_class <= CLS_OTHER;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ---- pcs_framer.sv ----
// Ordered-set framer: GMII transmit to code groups and code groups back to GMII receive.
`timescale 1ns/1ps
`default_nettype none
module pcs_framer
    import pcs_framer_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    input  wire logic [7:0]  i_txd,
    input  wire logic        i_tx_en,
    input  wire logic        i_tx_er,
    input  wire logic        i_config_en,
    input  wire logic [15:0] i_config_word,
    input  wire logic        i_disparity_pos,
    input  wire logic [7:0]  i_rx_cg_data,
    input  wire logic        i_rx_cg_k,
    output logic [7:0]       o_tx_cg_data,
    output logic             o_tx_cg_k,
    output logic             o_tx_even,
    output logic [7:0]       o_rxd,
    output logic             o_rx_dv,
    output logic             o_rx_er
);
    logic       rstn;
    tx_state_t  tx_state;
    tx_state_t  next_tx_state;
    logic       slot_even;
    logic       first_idle;
    logic       next_first_idle;
    logic       cfg_second;
    logic       next_cfg_second;
    logic [7:0] next_tx_data;
    logic       next_tx_k;
    rx_state_t  rx_state;
    rx_state_t  next_rx_state;
    logic [7:0] rx_data;
    cg_class_t  rx_class;
    logic [7:0] next_rxd;
    logic       next_rx_dv;
    logic       next_rx_er;

    reset_sync u_reset_sync (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .o_rstn  (rstn)
    );

    // The slot parity runs freely; the framing logic keeps frames in step with it.
    always_ff @(posedge i_clock or negedge rstn) begin
        if (!rstn) begin
            slot_even <= 1'b1;
            o_tx_even <= 1'b1;
        end else begin
            slot_even <= !slot_even;
            o_tx_even <= slot_even;
        end
    end

    always_comb begin
        next_tx_state   = tx_state;
        next_first_idle = first_idle;
        next_cfg_second = cfg_second;
        next_tx_data    = CG_K28_5;
        next_tx_k       = 1'b1;
        unique case (tx_state)
            TX_IDLE: begin
                if (slot_even) begin
                    if (i_config_en) begin
                        next_tx_state = TX_CFG1;
                    end else if (i_tx_en) begin
                        next_tx_data  = CG_SOP;
                        next_tx_state = TX_DATA;
                    end
                end else begin
                    next_tx_k       = 1'b0;
                    next_first_idle = 1'b0;
                    if (i_tx_en && !i_config_en) begin
                        // The idle must be completed, so this byte of preamble is lost.
                        next_tx_data  = CG_D16_2;
                        next_tx_state = TX_SOP;
                    end else if (first_idle && i_disparity_pos) begin
                        next_tx_data = CG_D5_6;
                    end else begin
                        next_tx_data = CG_D16_2;
                    end
                end
            end
            TX_SOP: begin
                next_tx_data  = CG_SOP;
                next_tx_state = TX_DATA;
            end
            TX_DATA: begin
                if (i_tx_en) begin
                    if (i_tx_er) begin
                        next_tx_data = CG_ERRPROP;
                    end else begin
                        next_tx_data = i_txd;
                        next_tx_k    = 1'b0;
                    end
                end else begin
                    next_tx_data    = CG_EOP;
                    next_first_idle = 1'b1;
                    next_tx_state   = slot_even ? TX_EXT1 : TX_EXT2;
                end
            end
            TX_EXT2: begin
                next_tx_data  = CG_EXTEND;
                next_tx_state = TX_EXT1;
            end
            TX_EXT1: begin
                next_tx_data  = CG_EXTEND;
                next_tx_state = TX_IDLE;
            end
            TX_CFG1: begin
                next_tx_k     = 1'b0;
                next_tx_data  = cfg_second ? CG_D2_2 : CG_D21_5;
                next_tx_state = TX_CFG2;
            end
            TX_CFG2: begin
                next_tx_k     = 1'b0;
                next_tx_data  = i_config_word[7:0];
                next_tx_state = TX_CFG3;
            end
            TX_CFG3: begin
                next_tx_k       = 1'b0;
                next_tx_data    = i_config_word[15:8];
                next_cfg_second = !cfg_second;
                next_tx_state   = TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge rstn) begin
        if (!rstn) begin
            tx_state   <= TX_IDLE;
            first_idle <= 1'b0;
            cfg_second <= 1'b0;
        end else begin
            tx_state   <= next_tx_state;
            first_idle <= next_first_idle;
            cfg_second <= next_cfg_second;
        end
    end

    always_ff @(posedge i_clock or negedge rstn) begin
        if (!rstn) begin
            o_tx_cg_data <= CG_K28_5;
            o_tx_cg_k    <= 1'b1;
        end else begin
            o_tx_cg_data <= next_tx_data;
            o_tx_cg_k    <= next_tx_k;
        end
    end

    cg_classify u_rx_classify (
        .i_clock (i_clock),
        .i_rstn  (rstn),
        .i_data  (i_rx_cg_data),
        .i_k     (i_rx_cg_k),
        .o_data  (rx_data),
        .o_class (rx_class)
    );

    // Idle and configuration sets simply leave the receiver idle; the D16.2 that
    // closed an odd-aligned idle is never turned back into preamble.
    always_comb begin
        next_rx_state = rx_state;
        next_rxd      = 8'h00;
        next_rx_dv    = 1'b0;
        next_rx_er    = 1'b0;
        unique case (rx_state)
            RX_IDLE: begin
                if (rx_class == CLS_SOP) begin
                    next_rxd      = PREAMBLE;
                    next_rx_dv    = 1'b1;
                    next_rx_state = RX_FRAME;
                end
            end
            RX_FRAME: begin
                unique case (rx_class)
                    CLS_DATA: begin
                        next_rxd   = rx_data;
                        next_rx_dv = 1'b1;
                    end
                    CLS_EOP: begin
                        next_rx_state = RX_TERM;
                    end
                    CLS_SOP: begin
                        next_rxd   = PREAMBLE;
                        next_rx_dv = 1'b1;
                    end
                    default: begin
                        // Error code or an unexpected control group corrupts the frame.
                        next_rx_dv = 1'b1;
                        next_rx_er = 1'b1;
                    end
                endcase
            end
            RX_TERM: begin
                next_rx_state = (rx_class == CLS_EXTEND) ? RX_TERM_R : RX_IDLE;
            end
            RX_TERM_R: begin
                if (rx_class == CLS_EXTEND) begin
                    next_rxd   = EXTEND_CODE;
                    next_rx_er = 1'b1;
                end
                next_rx_state = RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge rstn) begin
        if (!rstn) begin
            rx_state <= RX_IDLE;
            o_rxd    <= 8'h00;
            o_rx_dv  <= 1'b0;
            o_rx_er  <= 1'b0;
        end else begin
            rx_state <= next_rx_state;
            o_rxd    <= next_rxd;
            o_rx_dv  <= next_rx_dv;
            o_rx_er  <= next_rx_er;
        end
    end
endmodule
`default_nettype wire

// ---- pcs_framer_chk.sv ----
// Port-level assertions for the ordered-set framer.
`timescale 1ns/1ps
`default_nettype none
module pcs_framer_chk
    import pcs_framer_pkg::*;
(
    input wire logic        i_clock,
    input wire logic        i_rstn,
    input wire logic [7:0]  i_txd,
    input wire logic        i_tx_en,
    input wire logic        i_tx_er,
    input wire logic        i_config_en,
    input wire logic [15:0] i_config_word,
    input wire logic        i_disparity_pos,
    input wire logic [7:0]  i_rx_cg_data,
    input wire logic        i_rx_cg_k,
    input wire logic [7:0]  o_tx_cg_data,
    input wire logic        o_tx_cg_k,
    input wire logic        o_tx_even,
    input wire logic [7:0]  o_rxd,
    input wire logic        o_rx_dv,
    input wire logic        o_rx_er
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    wire logic tk_eop = o_tx_cg_k && o_tx_cg_data == CG_EOP;
    wire logic tk_ext = o_tx_cg_k && o_tx_cg_data == CG_EXTEND;
    wire logic tk_com = o_tx_cg_k && o_tx_cg_data == CG_K28_5;
    wire logic rk_ext = i_rx_cg_k && i_rx_cg_data == CG_EXTEND;
    wire logic dk_cfg = !o_tx_cg_k && (o_tx_cg_data == CG_D21_5 || o_tx_cg_data == CG_D2_2);

    sop_even_a: assert property (o_tx_cg_k && o_tx_cg_data == CG_SOP |-> o_tx_even)
        else $error("start code in odd slot");
    eop_even_a: assert property (tk_eop && o_tx_even |=> tk_ext ##1 tk_com)
        else $error("even end not closed by one extend");
    eop_odd_a: assert property (tk_eop && !o_tx_even |=> tk_ext ##1 tk_ext ##1 tk_com)
        else $error("odd end not closed by two extends");
    end_now_a: assert property ($fell(i_tx_en) && !o_tx_cg_k |=> tk_eop)
        else $error("end code late");
    err_code_a: assert property ($past(i_tx_en, 2) && i_tx_en && i_tx_er
        |=> o_tx_cg_k && o_tx_cg_data == CG_ERRPROP) else $error("error code missing");
    first_idle_a: assert property (tk_ext ##1 (tk_com && !i_tx_en) |=> !o_tx_cg_k
        && o_tx_cg_data == ($past(i_disparity_pos) ? CG_D5_6 : CG_D16_2))
        else $error("wrong first idle");
    rx_sop_a: assert property (i_rx_cg_k && i_rx_cg_data == CG_SOP
        |-> ##2 o_rx_dv && o_rxd == PREAMBLE) else $error("start not turned to preamble");
    rx_ext_a: assert property (i_rx_cg_k && i_rx_cg_data == CG_EOP ##1 rk_ext ##1 rk_ext
        |-> ##2 o_rx_er && !o_rx_dv && o_rxd == EXTEND_CODE) else $error("no frame extension");
    cfg_word_a: assert property (tk_com ##1 dk_cfg |=> !o_tx_cg_k
        && o_tx_cg_data == $past(i_config_word[7:0]) ##1 !o_tx_cg_k
        && o_tx_cg_data == $past(i_config_word[15:8])) else $error("config word bytes wrong");
    tx_data_a: assert property ($past(i_tx_en, 2) && $past(i_tx_en) && i_tx_en
        && !i_tx_er |=> !o_tx_cg_k && o_tx_cg_data == $past(i_txd))
        else $error("frame byte not passed");
endmodule
bind pcs_framer pcs_framer_chk pcs_framer_chk_i (.*);
`default_nettype wire

// ---- mac_model.sv ----
// MAC-side model: sends GMII frames and collects what the receiver hands back.
`timescale 1ns/1ps
`default_nettype none
module mac_model
    import pcs_framer_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic [7:0] i_rxd,
    input  wire logic       i_rx_dv,
    input  wire logic       i_rx_er,
    output logic [7:0]      o_txd,
    output logic            o_tx_en,
    output logic            o_tx_er
);
    logic [7:0] rxq[$];
    int         ext_n = 0;
    int         err_n = 0;
    initial begin
        o_txd = 8'h00;
        o_tx_en = 1'b0;
        o_tx_er = 1'b0;
    end
    always @(posedge i_clock) begin
        if (i_rx_dv) rxq.push_back(i_rxd);
        if (i_rx_dv && i_rx_er) err_n++;
        if (!i_rx_dv && i_rx_er && i_rxd == EXTEND_CODE) ext_n++;
    end
    // Released data is inverted so a stale byte cannot pass for a real one.
    task automatic send(input int n, input int er_at);
        for (int i = 0; i < n; i++) begin
            o_txd   <= 8'(i + 1);
            o_tx_en <= 1'b1;
            o_tx_er <= 1'(i == er_at);
            @(posedge i_clock);
        end
        o_txd   <= ~o_txd;
        o_tx_en <= 1'b0;
        o_tx_er <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Loopback bench: the MAC model feeds the framer, whose code groups return to its receiver.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import pcs_framer_pkg::*;
;
    logic        i_clock = 1'b0;
    logic        i_rstn = 1'b0;
    logic        i_config_en = 1'b0;
    logic [15:0] i_config_word = 16'h0000;
    logic        i_disparity_pos = 1'b0;
    logic [7:0]  i_txd, i_rx_cg_data, o_tx_cg_data, o_rxd;
    logic        i_tx_en, i_tx_er, i_rx_cg_k, o_tx_cg_k, o_tx_even, o_rx_dv, o_rx_er;
    logic [9:0]  txq[$];
    int          err_total = 0;
    int          compares = 0;

    assign i_rx_cg_data = o_tx_cg_data;
    assign i_rx_cg_k    = o_tx_cg_k;
    always #2.5 i_clock = ~i_clock;
    always @(posedge i_clock) txq.push_back({o_tx_even, o_tx_cg_k, o_tx_cg_data});
    pcs_framer pcs_framer_i (.*);
    mac_model mac_model_i (.i_clock(i_clock), .i_rxd(o_rxd), .i_rx_dv(o_rx_dv),
        .i_rx_er(o_rx_er), .o_txd(i_txd), .o_tx_en(i_tx_en), .o_tx_er(i_tx_er));

    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results;
        $display("%0d checks %0d errors", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    function automatic int find(input logic [8:0] v);
        find = -1;
        foreach (txq[i]) if (txq[i][8:0] === v) find = i;
    endfunction
    task automatic align(input logic odd);
        int w;
        w = 0;
        do begin
            @(posedge i_clock);
            w++;
        end while (o_tx_even !== !odd && w < 8);
        if (o_tx_even !== !odd) begin
            err_total++;
            results();
        end
    endtask
    task automatic config_case;
        logic [9:0] exp[8];
        int j;
        exp = '{10'h3bc, 10'h0b5, 10'h27c, 10'h0a3, 10'h3bc, 10'h042, 10'h27c, 10'h0a3};
        mac_model_i.rxq.delete();
        txq.delete();
        i_config_word <= 16'ha37c;
        i_config_en   <= 1'b1;
        repeat (7) @(posedge i_clock);
        i_config_en <= 1'b0;
        repeat (8) @(posedge i_clock);
        j = find({1'b0, CG_D21_5}) - 1;
        for (int i = 0; i < 8; i++) check("config", exp[i], txq[j + i]);
        check("rx quiet", 10'h000, 10'(mac_model_i.rxq.size()));
    endtask
    task automatic frame_case(input logic odd, input int n, input int er_at, input logic disp);
        int b, s, t, r, x, e;
        b = odd ? 2 : 1;
        x = (n + odd) % 2;
        e = er_at - b + 1;
        mac_model_i.rxq.delete();
        mac_model_i.ext_n = 0;
        mac_model_i.err_n = 0;
        i_disparity_pos <= disp;
        align(odd);
        txq.delete();
        mac_model_i.send(n, er_at);
        repeat (12) @(posedge i_clock);
        s = find({1'b1, CG_SOP});
        t = s + n - odd;
        r = find({1'b1, CG_EXTEND});
        check("start", {2'b11, CG_SOP}, txq[s]);
        check("first byte", {2'b00, 8'(b + 1)}, txq[s + 1]);
        if (odd) check("lead", {2'b00, CG_D16_2}, txq[s - 1]);
        check("end", {1'(x == 0), 1'b1, CG_EOP}, txq[t]);
        check("extends", 10'(x + 1), 10'(r - t));
        check("idle one", {2'b00, disp ? CG_D5_6 : CG_D16_2}, txq[r + 2]);
        check("idle two", {2'b00, CG_D16_2}, txq[r + 4]);
        if (er_at >= 0) check("err", {2'b01, CG_ERRPROP}, {1'b0, txq[s + e][8:0]});
        check("rx len", 10'(n - b + 1), 10'(mac_model_i.rxq.size()));
        check("preamble", {2'b00, PREAMBLE}, {2'b00, mac_model_i.rxq[0]});
        for (int i = 1; i < mac_model_i.rxq.size(); i++)
            if (i != e) check("rx byte", 10'(b + i), {2'b00, mac_model_i.rxq[i]});
        check("rx err", 10'(er_at >= 0), 10'(mac_model_i.err_n));
        check("rx ext", 10'(x), 10'(mac_model_i.ext_n));
    endtask

    initial begin
        repeat (20) @(posedge i_clock);
        i_rstn <= 1'b1;
        repeat (5) @(posedge i_clock);
        config_case();
        frame_case(1'b0, 8, -1, 1'b0);
        frame_case(1'b0, 9, 3, 1'b1);
        frame_case(1'b1, 8, -1, 1'b1);
        frame_case(1'b1, 7, 4, 1'b0);
        results();
    end
endmodule
`default_nettype wire
